// ==== core/ats_pkg.sv ====
// Package with register map, field positions and selection codes for the converter input select block.
package ats_pkg;

	// Register map; printed offsets are not multiples of four, so they are indices.
	localparam logic [19:0] ATS_IDX_TEST_SEL = 20'hF0013;
	localparam logic [19:0] ATS_IDX_CHAN_SEL = 20'hFFF31;
	localparam logic [19:0] ATS_IDX_CONV_CTL = 20'hF0014;
	localparam logic [19:0] ATS_IDX_STATUS   = 20'hF0015;
	localparam int          ATS_ADDR_W       = 22;
	localparam logic [21:0] ATS_ADDR_TEST_SEL = {ATS_IDX_TEST_SEL, 2'h0};
	localparam logic [21:0] ATS_ADDR_CHAN_SEL = {ATS_IDX_CHAN_SEL, 2'h0};
	localparam logic [21:0] ATS_ADDR_CONV_CTL = {ATS_IDX_CONV_CTL, 2'h0};
	localparam logic [21:0] ATS_ADDR_STATUS   = {ATS_IDX_STATUS, 2'h0};

	// Reset values.
	localparam logic [7:0] ATS_RST_TEST_SEL = 8'h00;
	localparam logic [7:0] ATS_RST_CHAN_SEL = 8'h00;
	localparam logic [7:0] ATS_RST_CONV_CTL = 8'h00;

	// Field positions.
	localparam int ATS_TEST_CODE_LO  = 0;
	localparam int ATS_TEST_CODE_HI  = 1;
	localparam int ATS_CHAN_CODE_LO  = 0;
	localparam int ATS_CHAN_CODE_HI  = 4;
	localparam int ATS_INT_REF_BIT   = 7;
	localparam int ATS_CTL_RUN       = 0;
	localparam int ATS_CTL_CMP_EN    = 1;
	localparam int ATS_CTL_SCAN_MODE = 2;
	localparam int ATS_CTL_PREF_LO   = 3;
	localparam int ATS_CTL_PREF_HI   = 4;

	// Test target codes.
	localparam logic [1:0] ATS_TEST_CHANNEL = 2'h0;
	localparam logic [1:0] ATS_TEST_BAD     = 2'h1;
	localparam logic [1:0] ATS_TEST_NEG_REF = 2'h2;
	localparam logic [1:0] ATS_TEST_POS_REF = 2'h3;

	// Channel codes.
	localparam logic [4:0] ATS_CH_ANI_FIRST = 5'h08;
	localparam logic [4:0] ATS_CH_ANI_LAST  = 5'h11;
	localparam logic [4:0] ATS_CH_BIAS      = 5'h12;
	localparam logic [4:0] ATS_CH_INT_REF   = 5'h01;

	// Positive reference source code that would pick the internal reference.
	localparam logic [1:0] ATS_PREF_INTERNAL = 2'h2;

	// Source select one-hot layout: 10 pins, bias, internal ref, neg ref, pos ref.
	localparam int ATS_NUM_ANI = 10;
	localparam int ATS_SRC_W   = 14;
	localparam int ATS_SRC_BIAS = 10;
	localparam int ATS_SRC_IREF = 11;
	localparam int ATS_SRC_NEG  = 12;
	localparam int ATS_SRC_POS  = 13;

	typedef enum logic [1:0] {
		ATS_BUS_IDLE,
		ATS_BUS_ANSWER
	} ats_bus_state_t;

endpackage

// ==== core/ats_src_decode.sv ====
// Combinational decoder from the two select registers and the scan mode bit to a one-hot source select.
`timescale 1ns/100ps
module ats_src_decode
	import ats_pkg::*;
(
	// Register fields.
	input  wire logic [1:0]               test_code,
	input  wire logic [4:0]               chan_code,
	input  wire logic                     int_ref_sel,
	input  wire logic                     scan_mode,
	// Result.
	output logic      [ATS_SRC_W-1:0]     src_onehot,
	output logic                          illegal
);
	logic [4:0] ani_idx;

	always_comb begin
		src_onehot = '0;
		illegal    = 1'b0;
		ani_idx    = 5'(chan_code - ATS_CH_ANI_FIRST);
		unique case (test_code)
			ATS_TEST_CHANNEL: begin
				if (int_ref_sel) begin
					if (chan_code == ATS_CH_INT_REF) begin
						src_onehot[ATS_SRC_IREF] = 1'b1;
					end else begin
						illegal = 1'b1;
					end
				end else if (scan_mode) begin
					// Scan mode sequencing is the converter's; no select from here.
					src_onehot = '0;
				end else if (chan_code >= ATS_CH_ANI_FIRST && chan_code <= ATS_CH_ANI_LAST) begin
					src_onehot[ani_idx[3:0]] = 1'b1;
				end else if (chan_code == ATS_CH_BIAS) begin
					src_onehot[ATS_SRC_BIAS] = 1'b1;
				end else begin
					illegal = 1'b1;
				end
			end
			ATS_TEST_BAD: begin
				illegal = 1'b1;
			end
			ATS_TEST_NEG_REF: begin
				src_onehot[ATS_SRC_NEG] = 1'b1;
			end
			ATS_TEST_POS_REF: begin
				src_onehot[ATS_SRC_POS] = 1'b1;
			end
		endcase
	end
endmodule

// ==== core/ats_first_discard.sv ====
// Tracker that flags the first conversion after the internal reference is selected.
`timescale 1ns/100ps
module ats_first_discard (
	// Clock and reset.
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Events.
	input  wire logic int_ref_rise,
	input  wire logic conv_done,
	// Flag.
	output logic      discard_r
);
	typedef struct packed {
		logic discard;
	} ats_disc_state_t;

	ats_disc_state_t st_r;
	ats_disc_state_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (conv_done) begin
			st_nxt.discard = 1'b0;
		end
		if (int_ref_rise) begin
			st_nxt.discard = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign discard_r = st_r.discard;
endmodule

// ==== core/ats_input_select.sv ====
// Converter input source selection with test target and channel select registers on Avalon-MM.
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module ats_input_select
	import ats_pkg::*;
(
	// Clock and reset.
	input  wire logic                    ref_clk,
	input  wire logic                    sys_rst,
	// Avalon-MM slave.
	input  wire logic [ATS_ADDR_W-1:0]   avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic      [31:0]             avs_readdata,
	output logic      [1:0]              avs_response,
	output logic                         avs_waitrequest,
	// Converter status.
	input  wire logic                    conv_done,
	// Converter controls.
	output logic                         conversion_run_bit,
	output logic                         comparator_enable_bit,
	output logic                         scan_select_mode_bit,
	output logic      [1:0]              positive_ref_source,
	// Source selection.
	output logic      [ATS_SRC_W-1:0]    src_select,
	output logic                         select_illegal,
	output logic                         result_discard
);
	import ats_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		ats_bus_state_t   bus;
		logic [7:0]       test_sel;
		logic [7:0]       chan_sel;
		logic [7:0]       conv_ctl;
		logic [31:0]      rdata;
		logic [1:0]       resp;
		logic             waitreq;
		logic             iref_prev;
		logic [ATS_SRC_W-1:0] src;
		logic             bad;
		logic             discard;
		logic [1:0]       pref_out;
	} ats_state_t;

	ats_state_t st_r;
	ats_state_t st_nxt;

	logic [ATS_SRC_W-1:0] dec_src;
	logic                 dec_bad;
	logic                 disc_flag;
	logic                 iref_rise;

	// Byte lane of a register index within the word; the three writable registers use lane 0, while the status word spans lanes 0 and 1.
	function automatic logic lane0_write(input logic [3:0] be);
		return be[0];
	endfunction

	function automatic logic conv_stopped(input logic [7:0] ctl);
		return !ctl[ATS_CTL_RUN] && !ctl[ATS_CTL_CMP_EN];
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Decoder and discard tracker.

	ats_src_decode u_decode (
		.test_code   (st_r.test_sel[ATS_TEST_CODE_HI:ATS_TEST_CODE_LO]),
		.chan_code   (st_r.chan_sel[ATS_CHAN_CODE_HI:ATS_CHAN_CODE_LO]),
		.int_ref_sel (st_r.chan_sel[ATS_INT_REF_BIT]),
		.scan_mode   (st_r.conv_ctl[ATS_CTL_SCAN_MODE]),
		.src_onehot  (dec_src),
		.illegal     (dec_bad)
	);

	assign iref_rise = st_r.chan_sel[ATS_INT_REF_BIT] && !st_r.iref_prev;

	ats_first_discard u_discard (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.int_ref_rise (iref_rise),
		.conv_done    (conv_done),
		.discard_r    (disc_flag)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		st_nxt           = st_r;
		st_nxt.iref_prev = st_r.chan_sel[ATS_INT_REF_BIT];
		st_nxt.src       = dec_src;
		st_nxt.bad       = dec_bad;
		st_nxt.discard   = disc_flag;
		// Internal reference withheld as positive reference.
		if (st_r.chan_sel[ATS_INT_REF_BIT] &&
				st_r.conv_ctl[ATS_CTL_PREF_HI:ATS_CTL_PREF_LO] == ATS_PREF_INTERNAL) begin
			st_nxt.pref_out = 2'h0;
		end else begin
			st_nxt.pref_out = st_r.conv_ctl[ATS_CTL_PREF_HI:ATS_CTL_PREF_LO];
		end
		unique case (st_r.bus)
			ATS_BUS_IDLE: begin
				st_nxt.waitreq = 1'b1;
				if (avs_read || avs_write) begin
					st_nxt.bus     = ATS_BUS_ANSWER;
					st_nxt.waitreq = 1'b0;
					st_nxt.rdata  = 32'h0000_0000;
					st_nxt.resp   = 2'h0;
					unique case (avs_address)
						ATS_ADDR_TEST_SEL: begin
							st_nxt.rdata = {24'h00_0000, st_r.test_sel};
							if (avs_write && lane0_write(avs_byteenable)) begin
								st_nxt.test_sel = avs_writedata[7:0];
							end
						end
						ATS_ADDR_CHAN_SEL: begin
							st_nxt.rdata = {24'h00_0000, st_r.chan_sel};
							// Byte write; bit writes land as read-modify-write.
							if (avs_write && lane0_write(avs_byteenable)) begin
								st_nxt.chan_sel = avs_writedata[7:0];
								// Internal ref bit held while running or while the comparator is enabled.
								if (!conv_stopped(st_r.conv_ctl)) begin
									st_nxt.chan_sel[ATS_INT_REF_BIT] = st_r.chan_sel[ATS_INT_REF_BIT];
								end
							end
						end
						ATS_ADDR_CONV_CTL: begin
							st_nxt.rdata = {24'h00_0000, st_r.conv_ctl};
							if (avs_write && lane0_write(avs_byteenable)) begin
								st_nxt.conv_ctl = avs_writedata[7:0];
							end
						end
						ATS_ADDR_STATUS: begin
							st_nxt.rdata = {16'h0000, st_r.src, st_r.bad, st_r.discard};
						end
						default: begin
							st_nxt.resp = 2'h2;
						end
					endcase
				end
			end
			ATS_BUS_ANSWER: begin
				st_nxt.bus     = ATS_BUS_IDLE;
				st_nxt.waitreq = 1'b1;
			end
			default: begin
				st_nxt.bus = ATS_BUS_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_r          <= '0;
			st_r.test_sel <= ATS_RST_TEST_SEL;
			st_r.chan_sel <= ATS_RST_CHAN_SEL;
			st_r.conv_ctl <= ATS_RST_CONV_CTL;
			st_r.bus      <= ATS_BUS_IDLE;
			st_r.waitreq  <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign avs_readdata          = st_r.rdata;
	assign avs_response          = st_r.resp;
	assign avs_waitrequest       = st_r.waitreq;
	assign conversion_run_bit    = st_r.conv_ctl[ATS_CTL_RUN];
	assign comparator_enable_bit = st_r.conv_ctl[ATS_CTL_CMP_EN];
	assign scan_select_mode_bit  = st_r.conv_ctl[ATS_CTL_SCAN_MODE];
	assign positive_ref_source   = st_r.pref_out;
	assign src_select            = st_r.src;
	assign select_illegal        = st_r.bad;
	assign result_discard        = st_r.discard;
endmodule

// ==== sim/ats_input_select_chk.sv ====
// Checker of the converter input select ports.
`timescale 1ns/100ps
module ats_input_select_chk
	import ats_pkg::*;
(
	// Clock and reset.
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	// Register bus.
	input wire logic [ATS_ADDR_W-1:0] avs_address,
	input wire logic                  avs_read,
	input wire logic                  avs_write,
	input wire logic [31:0]           avs_writedata,
	input wire logic [3:0]            avs_byteenable,
	input wire logic                  avs_waitrequest,
	// Converter side.
	input wire logic                  conversion_run_bit,
	input wire logic                  comparator_enable_bit,
	input wire logic                  scan_select_mode_bit,
	input wire logic [1:0]            positive_ref_source,
	input wire logic [ATS_SRC_W-1:0]  src_select,
	input wire logic                  select_illegal,
	input wire logic                  result_discard
);
	logic [1:0] tc_r;
	logic       ir_r;
	wire        tk  = avs_write && avs_waitrequest && avs_byteenable[0];
	wire        wt  = tk && avs_address == ATS_ADDR_TEST_SEL && !scan_select_mode_bit;
	wire        wc  = tk && avs_address == ATS_ADDR_CHAN_SEL;
	wire        idl = !conversion_run_bit && !comparator_enable_bit;
	wire        chn = wc && idl && !scan_select_mode_bit && tc_r == 2'h0;
	wire  [7:0] d   = avs_writedata[7:0];
	// Mirrors of the test code and the internal reference bit.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tc_r <= 2'h0;
			ir_r <= 1'b0;
		end else begin
			if (tk && avs_address == ATS_ADDR_TEST_SEL)
				tc_r <= d[1:0];
			if (wc && idl)
				ir_r <= d[7];
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	chk_wait_answer:
		assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
	chk_wait_single:
		assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
	chk_neg_ref:
		assert property (wt && d[1:0] == 2'h2 |-> ##2 src_select == 14'h1000) else $error("negative ref");
	chk_pos_ref:
		assert property (wt && d[1:0] == 2'h3 |-> ##2 src_select == 14'h2000) else $error("positive ref");
	chk_bad_test:
		assert property (wt && d[1:0] == 2'h1 |-> ##2 select_illegal && src_select == 14'h0) else $error("bad code");
	chk_chan_pin:
		assert property (chn && !d[7] && d[4:0] inside {[5'h08:5'h12]}
			|-> ##2 src_select == 14'h0001 << ($past(avs_writedata[4:0], 2) - 5'h08)) else $error("pin select");
	chk_int_ref:
		assert property (chn && d[7] && d[4:0] == 5'h01 |-> ##2 src_select == 14'h0800) else $error("int ref");
	chk_pref_bar:
		assert property ($past(ir_r) |-> positive_ref_source != ATS_PREF_INTERNAL) else $error("pref barred");
	chk_discard_on:
		assert property (wc && idl && d[7] && !ir_r |-> ##[1:3] result_discard) else $error("no discard");
	chk_reset_clear:
		assert property ($past(sys_rst) |-> src_select == 14'h0 && !select_illegal) else $error("reset state");
endmodule
bind ats_input_select ats_input_select_chk i_chk (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_byteenable, .avs_waitrequest, .conversion_run_bit, .comparator_enable_bit,
	.scan_select_mode_bit, .positive_ref_source, .src_select, .select_illegal, .result_discard);

// ==== sim/adc_input_test_select_tb.sv ====
// Self-checking bench for the converter input select block.
`timescale 1ns/100ps
module adc_input_test_select_tb;
	import ats_pkg::*;
	logic                  ref_clk;
	logic                  sys_rst;
	logic [ATS_ADDR_W-1:0] adr;
	logic                  rd_en;
	logic                  wr_en;
	logic [31:0]           wdat;
	logic [3:0]            ben;
	logic [31:0]           rdat;
	logic [1:0]            resp;
	logic                  wreq;
	logic                  done;
	logic                  run_o;
	logic                  cmp_o;
	logic                  scan_o;
	logic [1:0]            pref;
	logic [13:0]           src;
	logic                  ill;
	logic                  disc;
	int                    tc;
	int                    ch;
	int                    ctl;
	int                    dm;
	int                    seed;
	int                    failures;
	int                    checks;
	ats_input_select i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(adr), .avs_read(rd_en),
		.avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(ben), .avs_readdata(rdat), .avs_response(resp),
		.avs_waitrequest(wreq), .conv_done(done), .conversion_run_bit(run_o), .comparator_enable_bit(cmp_o),
		.scan_select_mode_bit(scan_o), .positive_ref_source(pref), .src_select(src), .select_illegal(ill),
		.result_discard(disc));
	task automatic cmp_reg(input logic [33:0] got, input logic [33:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: read %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_out(input logic [20:0] got, input logic [20:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: outputs %h, expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [19:0] exp_out();
		logic [13:0] s;
		logic        il;
		int          p;
		int          c;
		s = '0;
		il = 1'b0;
		c = ch & 31;
		p = (ctl >> 3) & 3;
		if (ch[7] && p == 2)
			p = 0;
		if ((tc & 3) == 1)
			il = 1'b1;
		else if ((tc & 3) == 2)
			s[12] = 1'b1;
		else if ((tc & 3) == 3)
			s[13] = 1'b1;
		else if (ch[7] && c == 1)
			s[11] = 1'b1;
		else if (ch[7])
			il = 1'b1;
		else if (ctl[2]) begin
		end else if (c >= 8 && c <= 18)
			s[c - 8] = 1'b1;
		else
			il = 1'b1;
		return {ctl[2:0], p[1:0], il, s};
	endfunction
	task automatic acc(input logic w, input logic [21:0] a, input logic [7:0] d, input logic b);
		logic [33:0] e;
		logic [19:0] eo;
		logic        p7;
		adr <= a;
		rd_en <= !w;
		wr_en <= w;
		wdat <= {24'h0, d};
		ben <= {4{b}};
		do begin
			@(posedge ref_clk);
		end while (wreq !== 1'b0);
		eo = exp_out();
		if (a == ATS_ADDR_TEST_SEL)
			e = 34'(tc);
		else if (a == ATS_ADDR_CHAN_SEL)
			e = 34'(ch);
		else if (a == ATS_ADDR_STATUS)
			e = {18'h0, eo[13:0], eo[14], 1'(dm)};
		else
			e = {2'h2, 32'h0};
		if (!w)
			cmp_reg({resp, rdat}, e);
		if (w && b) begin
			p7 = ch[7];
			if (a == ATS_ADDR_TEST_SEL)
				tc = d;
			if (a == ATS_ADDR_CHAN_SEL)
				ch = (ctl & 3) != 0 ? {ch[7], d[6:0]} : d;
			if (ch[7] && !p7)
				dm = 1;
			if (a == ATS_ADDR_CONV_CTL)
				ctl = d;
		end
		rd_en <= 1'b0;
		wr_en <= 1'b0;
		@(posedge ref_clk);
		cmp_out({1'b0, scan_o, cmp_o, run_o, pref, ill, src}, {1'b0, exp_out()});
	endtask
	task automatic pulse_done();
		done <= 1'b1;
		@(posedge ref_clk);
		done <= 1'b0;
		dm = 0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		complete_run();
	end
	initial begin
		seed = 2959;
		sys_rst = 1'b1;
		{adr, rd_en, wr_en, wdat, ben, done} = '0;
		{tc, ch, ctl, dm, failures, checks} = '0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		acc(0, ATS_ADDR_TEST_SEL, 8'h00, 1);
		acc(0, ATS_ADDR_CHAN_SEL, 8'h00, 1);
		acc(1, ATS_ADDR_CHAN_SEL, 8'h08, 1);
		for (int i = 0; i < 5; i++)
			acc(1, ATS_ADDR_TEST_SEL, 8'(i & 3), 1);
		for (int i = 0; i < 64; i++)
			acc(1, ATS_ADDR_CHAN_SEL, {i[5], 2'h0, i[4:0]}, 1);
		// A finished conversion clears the flag; picking the internal reference sets it again.
		acc(1, ATS_ADDR_CHAN_SEL, 8'h08, 1);
		pulse_done();
		cmp_reg({33'h0, disc}, 34'h0);
		acc(1, ATS_ADDR_CHAN_SEL, 8'h81, 1);
		@(posedge ref_clk);
		cmp_reg({33'h0, disc}, 34'h1);
		acc(0, ATS_ADDR_STATUS, 8'h00, 1);
		pulse_done();
		cmp_reg({33'h0, disc}, 34'h0);
		acc(0, ATS_ADDR_STATUS, 8'h00, 1);
		acc(1, ATS_ADDR_CONV_CTL, 8'h04, 1);
		acc(1, ATS_ADDR_CONV_CTL, 8'h10, 1);
		acc(1, ATS_ADDR_CONV_CTL, 8'h11, 1);
		acc(1, ATS_ADDR_CHAN_SEL, 8'h08, 1);
		acc(0, ATS_ADDR_CHAN_SEL, 8'h00, 1);
		acc(1, ATS_ADDR_CONV_CTL, 8'h00, 1);
		acc(1, ATS_ADDR_TEST_SEL, 8'h03, 0);
		acc(0, ATS_ADDR_TEST_SEL, 8'h00, 1);
		acc(0, 22'h000100, 8'h00, 1);
		for (int i = 0; i < 24; i++) begin
			acc(1, ATS_ADDR_CONV_CTL, 8'($random(seed)) & 8'h1B, 1);
			acc(1, ATS_ADDR_TEST_SEL, 8'($random(seed)) & 8'h03, 1);
			acc(1, ATS_ADDR_CHAN_SEL, 8'($random(seed)) & 8'h9F, 1);
		end
		// Stop the converter and drop the internal reference, then reset in mid-run.
		acc(1, ATS_ADDR_CONV_CTL, 8'h00, 1);
		acc(1, ATS_ADDR_CHAN_SEL, 8'h08, 1);
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		{tc, ch, ctl, dm} = '0;
		@(posedge ref_clk);
		acc(0, ATS_ADDR_TEST_SEL, 8'h00, 1);
		acc(0, ATS_ADDR_CHAN_SEL, 8'h00, 1);
		complete_run();
	end
endmodule
